// ---- logic/dcfrf_pkg.sv ----
// constants shared by the read-port and flag block of the dual-clock fifo
// assumes all pin inputs are sampled by one fast system clock
package dcfrf_pkg;
   // documented organisation
   localparam int DCFRF_WIDTH = 18;
   localparam int DCFRF_DEPTH = 32768;
   localparam int DCFRF_OFS_W = 15;
   // default offsets picked by the load strap at full reset
   localparam int DCFRF_OFS_DEF_PAR = 127;
   localparam int DCFRF_OFS_DEF_SER = 1023;
   // bit positions of the sampled pin vector, data sits above them
   localparam int PIN_WCLK = 0;
   localparam int PIN_RCLK = 1;
   localparam int PIN_WEN = 2;
   localparam int PIN_REN = 3;
   localparam int PIN_SEN = 4;
   localparam int PIN_LD = 5;
   localparam int PIN_SI = 6;
   localparam int PIN_OE = 7;
   localparam int PIN_FRST = 8;
   localparam int PIN_PRST = 9;
   localparam int PIN_CTL_W = 10;
   // entries of the write-side staging buffer
   localparam int DCFRF_BUF_DEPTH = 2;
endpackage

// ---- logic/dcfrf_skid.sv ----
// two-entry staging buffer with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/100ps
module dcfrf_skid
   import dcfrf_pkg::*;
#(
   parameter int W = DCFRF_WIDTH
)
(
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_flush,
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [W-1:0] i_data,
   output logic o_valid,
   input wire logic i_ready,
   output logic [W-1:0] o_data,
   output logic [1:0] o_level
);
   typedef struct packed {
      logic [DCFRF_BUF_DEPTH-1:0][W-1:0] mem;
      logic wp;
      logic rp;
      logic [1:0] lvl;
   } dcfrf_skid_s;

   dcfrf_skid_s st_q;
   dcfrf_skid_s st_d;
   logic push;
   logic pop;

   if (W < 1)
   begin : g_bad_cfg
      $error("dcfrf_skid: W must be positive");
   end

   assign o_ready = st_q.lvl != 2'(DCFRF_BUF_DEPTH);
   assign o_valid = st_q.lvl != 2'h0;
   assign o_data = st_q.mem[st_q.rp];
   assign o_level = st_q.lvl;
   assign push = i_valid & o_ready;
   assign pop = o_valid & i_ready;

   always_comb
   begin
      st_d = st_q;
      if (push)
      begin
         st_d.mem[st_q.wp] = i_data;
         st_d.wp = ~st_q.wp;
      end
      if (pop)
         st_d.rp = ~st_q.rp;
      st_d.lvl = st_q.lvl + 2'(push) - 2'(pop);
      if (i_flush)
      begin
         st_d.wp = 1'b0;
         st_d.rp = 1'b0;
         st_d.lvl = 2'h0;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   a_skid_bound: assert property (st_q.lvl <= 2'(DCFRF_BUF_DEPTH))
      else $error("staging buffer over capacity");
endmodule

// ---- logic/dcfrf_fifo.sv ----
// read port, offset programming and status flags of a dual-clock fifo
// assumes both fifo clocks are pins sampled by i_clk, well below its rate
`timescale 1ns/100ps

// How it works
// - read enable low, not empty: next word out
// - read enable high keeps output register, except fall-through loading an empty output
// - standard mode: every read requested, empty ignores reads
// - standard empty flag rises two read edges later
// - fall-through: first word out on third edge
// - output ready low with first valid word
// - output ready rises only on true read
// - serial load shifts one bit per write edge
// - serial method: serial enable high leaves offsets alone
// - drive enable low drives data, else float
// - load strap picks default offsets and method
// - offset access uses strapped method, reads parallel
// - standard full flag low after depth words
// - fall-through input ready counts output word
// - full flag on write clock, two stages
// - empty flag two stages, fall-through three
// - almost full at capacity minus full offset
// - almost empty at offset, plus one fall-through
// - half full set by write, cleared by read
// - half full thresholds per timing mode
// - mode strap at full reset, then serial input
// - resets clear pointers, partial keeps offsets
// - writes ignored while full
module dcfrf_fifo
   import dcfrf_pkg::*;
#(
   parameter int WIDTH = DCFRF_WIDTH,
   parameter int DEPTH = DCFRF_DEPTH,
   parameter int OFS_W = DCFRF_OFS_W
)
(
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_write_clock,
   input wire logic i_read_clock,
   input wire logic i_write_enable_n,
   input wire logic i_read_enable_n,
   input wire logic [WIDTH-1:0] i_write_data,
   input wire logic i_serial_load_en_n,
   input wire logic i_offset_access_n,
   input wire logic i_mode_select_serial_in,
   input wire logic i_output_drive_en_n,
   input wire logic i_full_reset_n,
   input wire logic i_partial_reset_n,
   output logic [WIDTH-1:0] o_read_data_out,
   output logic o_read_data_oe_n,
   output logic o_full_flag_n,
   output logic o_empty_flag_n,
   output logic o_almost_full_n,
   output logic o_almost_empty_n,
   output logic o_half_full_n,
   output logic o_fall_through_mode
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 2;
   localparam int PIN_W = PIN_CTL_W + WIDTH;

   typedef struct packed {
      logic [PIN_W-1:0] s1;
      logic [PIN_W-1:0] s2;
      logic wclk_d;
      logic rclk_d;
      logic fall_through_mode;
      logic serial;
      logic [OFS_W-1:0] ofs_e;
      logic [OFS_W-1:0] ofs_f;
      logic wsel;
      logic rsel;
      logic [PW-1:0] wr_bin;
      logic [PW-1:0] wr_gray;
      logic [PW-1:0] rd_bin;
      logic [PW-1:0] rd_gray;
      logic [PW-1:0] wg1;
      logic [PW-1:0] wg2;
      logic [PW-1:0] rg1;
      logic [PW-1:0] rg2;
      logic out_valid;
      logic [WIDTH-1:0] dout;
      logic oe_n;
      logic ff_a;
      logic ff_n;
      logic ef_n;
      logic af_n;
      logic ae_n;
      logic hf_n;
   } dcfrf_state_s;

   dcfrf_state_s st_q;
   dcfrf_state_s st_d;
   logic [WIDTH-1:0] mem_q [DEPTH];

   logic wr_rise;
   logic rd_rise;
   logic full_rst;
   logic dev_rst;
   logic ren;
   logic wen;
   logic ldl;
   logic mem_has;
   logic push;
   logic drain;
   logic mem_room;
   logic buf_in_ready;
   logic buf_valid;
   logic [WIDTH-1:0] buf_dout;
   logic [1:0] buf_lvl;
   logic [WIDTH-1:0] pin_data;
   logic [PW-1:0] wseen_b;
   logic [PW-1:0] rseen_b;
   logic [PW-1:0] tot_w;
   logic [PW-1:0] tot_true;
   logic [PW-1:0] cap;
   logic [PW-1:0] hf_lim;

   if (DEPTH < 4 || (1 << AW) != DEPTH || OFS_W > AW || OFS_W < 2 ||
       WIDTH < OFS_W)
   begin : g_bad_cfg
      $error("dcfrf_fifo: unsupported WIDTH, DEPTH or OFS_W");
   end

   function automatic logic [PW-1:0] g2b(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b = g;
      for (int k = PW - 2; k >= 0; k--)
         b[k] = b[k+1] ^ g[k];
      return b;
   endfunction

   function automatic logic [PW-1:0] b2g(input logic [PW-1:0] b);
      return b ^ (b >> 1);
   endfunction

   // edge strobes and levels from the second sampling stage only
   assign wr_rise = st_q.s2[PIN_WCLK] & ~st_q.wclk_d;
   assign rd_rise = st_q.s2[PIN_RCLK] & ~st_q.rclk_d;
   assign full_rst = ~st_q.s2[PIN_FRST];
   assign dev_rst = full_rst | ~st_q.s2[PIN_PRST];
   assign ren = ~st_q.s2[PIN_REN];
   assign wen = ~st_q.s2[PIN_WEN];
   assign ldl = ~st_q.s2[PIN_LD];
   assign pin_data = st_q.s2[PIN_CTL_W +: WIDTH];

   // write pointer seen by the read side, one stage more in fall-through
   assign wseen_b = g2b(st_q.fall_through_mode ? st_q.wg2 : st_q.wg1);
   assign rseen_b = g2b(st_q.rg2);
   assign mem_has = wseen_b != st_q.rd_bin;
   assign cap = PW'(DEPTH) + PW'(st_q.fall_through_mode);
   assign hf_lim = PW'(DEPTH / 2) + PW'(st_q.fall_through_mode);
   // stale read pointer only over-counts, so refusal is safe
   assign tot_w = st_q.wr_bin - rseen_b + PW'(buf_lvl);
   assign tot_true = st_q.wr_bin + PW'(buf_lvl) - st_q.rd_bin
      + PW'(st_q.fall_through_mode & st_q.out_valid);
   assign push = wr_rise & wen & ~ldl & ~dev_rst & (tot_w < cap)
      & buf_in_ready;
   assign mem_room = ((st_q.wr_bin - st_q.rd_bin) < PW'(DEPTH)) & ~dev_rst;
   assign drain = buf_valid & mem_room;

   dcfrf_skid #(
      .W(WIDTH)
   ) u_stage (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_flush(dev_rst),
      .i_valid(push),
      .o_ready(buf_in_ready),
      .i_data(pin_data),
      .o_valid(buf_valid),
      .i_ready(mem_room),
      .o_data(buf_dout),
      .o_level(buf_lvl)
   );

   always_comb
   begin
      logic [PW-1:0] tot_r;
      logic [PW-1:0] tot_n;
      logic [PW-1:0] tot_h;
      tot_r = '0;
      tot_n = '0;
      tot_h = '0;
      st_d = st_q;
      st_d.s1 = {i_write_data, i_partial_reset_n, i_full_reset_n,
         i_output_drive_en_n, i_mode_select_serial_in, i_offset_access_n,
         i_serial_load_en_n, i_read_enable_n, i_write_enable_n,
         i_read_clock, i_write_clock};
      st_d.s2 = st_q.s1;
      st_d.wclk_d = st_q.s2[PIN_WCLK];
      st_d.rclk_d = st_q.s2[PIN_RCLK];
      st_d.oe_n = st_q.s2[PIN_OE];

      // read side, one step per read clock edge
      if (rd_rise && !dev_rst)
      begin
         st_d.wg1 = st_q.wr_gray;
         st_d.wg2 = st_q.wg1;
         if (ldl && ren)
         begin
            // offset read-back is always parallel
            st_d.dout = WIDTH'(st_q.rsel ? st_q.ofs_f : st_q.ofs_e);
            st_d.rsel = ~st_q.rsel;
         end
         else if (!st_q.fall_through_mode)
         begin
            if (ren && st_q.ef_n && mem_has)
            begin
               st_d.dout = mem_q[st_q.rd_bin[AW-1:0]];
               st_d.rd_bin = st_q.rd_bin + PW'(1);
            end
            st_d.ef_n = st_d.rd_bin != wseen_b;
         end
         else
         begin
            if (mem_has && (!st_q.out_valid || ren))
            begin
               st_d.dout = mem_q[st_q.rd_bin[AW-1:0]];
               st_d.rd_bin = st_q.rd_bin + PW'(1);
               st_d.out_valid = 1'b1;
            end
            else if (ren)
               st_d.out_valid = 1'b0;
            st_d.ef_n = ~st_d.out_valid;
         end
         tot_r = wseen_b - st_d.rd_bin + PW'(st_q.fall_through_mode & st_d.out_valid);
         st_d.ae_n = ~(tot_r <= PW'(st_q.ofs_e) + PW'(st_q.fall_through_mode));
         tot_h = st_q.wr_bin + PW'(buf_lvl) - st_d.rd_bin
            + PW'(st_q.fall_through_mode & st_d.out_valid);
         if (tot_h <= hf_lim)
            st_d.hf_n = 1'b1;
         // published pointer counts the word held at the outputs
         st_d.rd_gray = b2g(st_d.rd_bin
            - PW'(st_q.fall_through_mode & st_d.out_valid));
      end

      // write side, one step per write clock edge
      if (wr_rise && !dev_rst)
      begin
         st_d.rg1 = st_q.rd_gray;
         st_d.rg2 = st_q.rg1;
         if (ldl && wen && !st_q.serial)
         begin
            if (st_q.wsel)
               st_d.ofs_f = pin_data[OFS_W-1:0];
            else
               st_d.ofs_e = pin_data[OFS_W-1:0];
            st_d.wsel = ~st_q.wsel;
         end
         if (ldl && st_q.serial && !st_q.s2[PIN_SEN])
         begin
            st_d.ofs_f = {st_q.ofs_f[OFS_W-2:0], st_q.ofs_e[OFS_W-1]};
            st_d.ofs_e = {st_q.ofs_e[OFS_W-2:0], st_q.s2[PIN_SI]};
         end
         tot_n = tot_w + PW'(push);
         st_d.ff_a = tot_n >= cap;
         st_d.ff_n = st_q.fall_through_mode ? st_q.ff_a : ~st_q.ff_a;
         st_d.af_n = ~(tot_n >= cap - PW'(st_q.ofs_f));
         if (tot_true + PW'(push) > hf_lim)
            st_d.hf_n = 1'b0;
      end

      // staged words enter memory while room remains
      if (drain)
      begin
         st_d.wr_bin = st_q.wr_bin + PW'(1);
         st_d.wr_gray = b2g(st_d.wr_bin);
      end

      // straps are caught while full reset is held
      if (full_rst)
      begin
         st_d.fall_through_mode = st_q.s2[PIN_SI];
         st_d.serial = st_q.s2[PIN_LD];
         st_d.ofs_e = st_q.s2[PIN_LD] ? OFS_W'(DCFRF_OFS_DEF_SER)
            : OFS_W'(DCFRF_OFS_DEF_PAR);
         st_d.ofs_f = st_d.ofs_e;
      end
      // partial reset leaves offsets and method in place
      if (dev_rst)
      begin
         st_d.wr_bin = '0;
         st_d.wr_gray = '0;
         st_d.rd_bin = '0;
         st_d.rd_gray = '0;
         st_d.wg1 = '0;
         st_d.wg2 = '0;
         st_d.rg1 = '0;
         st_d.rg2 = '0;
         st_d.wsel = 1'b0;
         st_d.rsel = 1'b0;
         st_d.out_valid = 1'b0;
         st_d.dout = '0;
         st_d.ff_a = 1'b0;
         st_d.ff_n = ~st_d.fall_through_mode;
         st_d.ef_n = st_d.fall_through_mode;
         st_d.af_n = 1'b1;
         st_d.ae_n = 1'b0;
         st_d.hf_n = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         st_q <= '0;
         st_q.oe_n <= 1'b1;
         st_q.ff_n <= 1'b1;
         st_q.af_n <= 1'b1;
         st_q.hf_n <= 1'b1;
      end
      else
         st_q <= st_d;
   end

   always_ff @(posedge i_clk)
   begin
      if (drain)
         mem_q[st_q.wr_bin[AW-1:0]] <= buf_dout;
   end

   assign o_read_data_out = st_q.dout;
   assign o_read_data_oe_n = st_q.oe_n;
   assign o_full_flag_n = st_q.ff_n;
   assign o_empty_flag_n = st_q.ef_n;
   assign o_almost_full_n = st_q.af_n;
   assign o_almost_empty_n = st_q.ae_n;
   assign o_half_full_n = st_q.hf_n;
   assign o_fall_through_mode = st_q.fall_through_mode;

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   a_std_read_step: assert property (
      rd_rise && !dev_rst && !st_q.fall_through_mode && !ldl && ren && st_q.ef_n
      && mem_has |=> st_q.rd_bin == $past(st_q.rd_bin) + PW'(1))
      else $error("standard read did not advance");
   a_output_hold: assert property (
      !dev_rst && !(rd_rise && (ren || (st_q.fall_through_mode && !st_q.out_valid)))
      |=> $stable(o_read_data_out))
      else $error("output changed without a read");
   a_empty_ignored: assert property (
      rd_rise && !dev_rst && !st_q.fall_through_mode && !st_q.ef_n
      |=> $stable(st_q.rd_bin))
      else $error("read taken while empty");
   a_ready_with_word: assert property (
      st_q.fall_through_mode && $rose(st_q.out_valid) |-> !o_empty_flag_n)
      else $error("output ready late for first word");
   a_last_word_kept: assert property (
      rd_rise && !dev_rst && st_q.fall_through_mode && !ldl && ren && st_q.out_valid
      && !mem_has |=> o_empty_flag_n && $stable(o_read_data_out))
      else $error("last word lost on final read");
   a_serial_hold: assert property (
      !full_rst && st_q.serial && st_q.s2[PIN_SEN]
      |=> $stable({st_q.ofs_f, st_q.ofs_e}))
      else $error("offsets changed with serial enable high");
   a_drive_follow: assert property (
      $fell(st_q.s2[PIN_OE]) |=> !o_read_data_oe_n)
      else $error("data bus not driven after enable");
   a_no_overflow: assert property (
      tot_true <= cap)
      else $error("fifo holds more than capacity");
   a_reset_ptrs: assert property (
      dev_rst |=> st_q.rd_bin == '0 && st_q.wr_bin == '0 && buf_lvl == 2'h0)
      else $error("pointers not cleared by reset");
   a_mode_strap: assert property (
      full_rst |=> st_q.fall_through_mode == $past(st_q.s2[PIN_SI]))
      else $error("mode strap not captured");
   a_default_offset: assert property (
      full_rst && ldl |=> st_q.ofs_e == OFS_W'(DCFRF_OFS_DEF_PAR)
      && !st_q.serial)
      else $error("parallel default offset wrong");

   c_fall_through: cover property (st_q.fall_through_mode && $rose(st_q.out_valid));
   c_reach_full: cover property (push && tot_w + PW'(1) == cap);
   c_serial_shift: cover property (wr_rise && st_q.serial && ldl
      && !st_q.s2[PIN_SEN] && !dev_rst);
   c_half_full: cover property ($fell(o_half_full_n));
endmodule

// ---- sim/dcfrf_far_model.sv ----
// far-side model: writer and reader logic on two slow fifo clocks
// assumes i_clk is the fast bench clock; fifo clocks derive from it
`timescale 1ns/100ps
module dcfrf_far_model
   import dcfrf_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_arst_n,
   output logic o_write_clock,
   output logic o_read_clock,
   output logic o_write_enable_n,
   output logic o_read_enable_n,
   output logic [DCFRF_WIDTH-1:0] o_write_data
);
   logic [2:0] wdiv_q;
   logic [2:0] rdiv_q;

   // periods of 8 and 10 fast cycles keep the two sides drifting
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         wdiv_q <= 3'h0;
         rdiv_q <= 3'h0;
         o_write_clock <= 1'b0;
         o_read_clock <= 1'b0;
      end
      else
      begin
         wdiv_q <= (wdiv_q == 3'h3) ? 3'h0 : wdiv_q + 3'h1;
         rdiv_q <= (rdiv_q == 3'h4) ? 3'h0 : rdiv_q + 3'h1;
         if (wdiv_q == 3'h3)
            o_write_clock <= ~o_write_clock;
         if (rdiv_q == 3'h4)
            o_read_clock <= ~o_read_clock;
      end
   end

   initial
   begin
      o_write_enable_n = 1'b1;
      o_read_enable_n = 1'b1;
      o_write_data = 18'h2aaaa;
   end

   // one word per write edge; released data is inverted, not held
   task automatic push(input logic [DCFRF_WIDTH-1:0] d);
      @(negedge o_write_clock);
      #1;
      o_write_enable_n = 1'b0;
      o_write_data = d;
      @(negedge o_write_clock);
      #1;
      o_write_enable_n = 1'b1;
      o_write_data = ~d;
   endtask

   // each word, in standard mode the first too, is requested on its own read edge
   task automatic pull();
      @(negedge o_read_clock);
      #1;
      o_read_enable_n = 1'b0;
      @(negedge o_read_clock);
      #1;
      o_read_enable_n = 1'b1;
   endtask
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the fifo read port, offsets and flags
// assumes dcfrf_far_model plays writer and reader on slow clocks
`timescale 1ns/100ps
module tb;
   import dcfrf_pkg::*;
   localparam int D = 16;
   localparam int NOFS = 3;
   localparam int MOFS = 2;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic sen_n = 1'b1;
   logic ld_n = 1'b1;
   logic si = 1'b0;
   logic oe_n = 1'b0;
   logic frst_n = 1'b0;
   logic prst_n = 1'b1;
   wire logic wclk;
   wire logic rclk;
   wire logic wen_n;
   wire logic ren_n;
   wire logic [17:0] wdata;
   logic [17:0] q;
   logic oq_n, ff_n, ef_n, af_n, ae_n, hf_n, ft;
   logic [17:0] words [0:D];
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   integer seed = 32'hb522cff7;

   initial
   begin
      forever #4 i_clk = ~i_clk;
   end

   dcfrf_fifo #(.DEPTH(D), .OFS_W(4)) dcfrf_fifo_i (.i_clk(i_clk),
      .i_arst_n(i_arst_n), .i_write_clock(wclk), .i_read_clock(rclk),
      .i_write_enable_n(wen_n), .i_read_enable_n(ren_n),
      .i_write_data(wdata), .i_serial_load_en_n(sen_n),
      .i_offset_access_n(ld_n), .i_mode_select_serial_in(si),
      .i_output_drive_en_n(oe_n), .i_full_reset_n(frst_n),
      .i_partial_reset_n(prst_n), .o_read_data_out(q),
      .o_read_data_oe_n(oq_n), .o_full_flag_n(ff_n),
      .o_empty_flag_n(ef_n), .o_almost_full_n(af_n),
      .o_almost_empty_n(ae_n), .o_half_full_n(hf_n),
      .o_fall_through_mode(ft));

   dcfrf_far_model dcfrf_far_model_i (.i_clk(i_clk), .i_arst_n(i_arst_n),
      .o_write_clock(wclk), .o_read_clock(rclk),
      .o_write_enable_n(wen_n), .o_read_enable_n(ren_n),
      .o_write_data(wdata));

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         bad_count++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // flag vector {full, empty, almost full, almost empty, half}
   task automatic chkf(input logic [4:0] exp);
      logic [4:0] got;
      got = {ff_n, ef_n, af_n, ae_n, hf_n};
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [4:0] expf(input int c, input bit f);
      if (f)
         return {c >= D + 1, !(c > 0), !(c >= D + 1 - MOFS),
            !(c <= NOFS + 1), !(c >= D / 2 + 2)};
      return {!(c >= D), c > 0, !(c >= D - MOFS), !(c <= NOFS),
         !(c > D / 2)};
   endfunction

   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic reset_all(input logic mode, input logic ld);
      step(1);
      i_arst_n = 1'b0;
      frst_n = 1'b0;
      si = mode;
      ld_n = ld;
      step(3);
      i_arst_n = 1'b1;
      step(6);
      frst_n = 1'b1;
      step(4);
      si = 1'b0;
      ld_n = 1'b1;
      step(10);
   endtask

   // offsets read back in parallel: empty offset first, then full
   task automatic ofs_check();
      ld_n = 1'b0;
      dcfrf_far_model_i.pull();
      step(60);
      chk(q, 18'(NOFS));
      dcfrf_far_model_i.pull();
      step(60);
      chk(q, 18'(MOFS));
      ld_n = 1'b1;
   endtask

   task automatic fill_drain(input bit f);
      int lim;
      int c;
      int idx;
      lim = D + f;
      for (int k = 0; k <= lim; k++)
      begin
         words[k] = 18'($random(seed));
         dcfrf_far_model_i.push(words[k]);
         step(60);
         c = (k < lim) ? k + 1 : lim;
         chkf(expf(c, f));
         if (f)
            chk(q, words[0]);
      end
      for (int k = 1; k <= lim + 1; k++)
      begin
         dcfrf_far_model_i.pull();
         step(60);
         c = (k < lim) ? lim - k : 0;
         idx = (k - 1 + f > lim - 1) ? lim - 1 : k - 1 + f;
         chkf(expf(c, f));
         chk(q, words[idx]);
      end
      $display("test fill and drain mode %0d done", f);
   endtask

   initial
   begin
      reset_all(1'b0, 1'b0);
      chk(18'(ft), 18'h0);
      chkf(expf(0, 1'b0));
      ld_n = 1'b0;
      dcfrf_far_model_i.push(18'(NOFS));
      dcfrf_far_model_i.push(18'(MOFS));
      ld_n = 1'b1;
      ofs_check();
      fill_drain(1'b0);
      oe_n = 1'b1;
      step(10);
      chk(18'(oq_n), 18'h1);
      oe_n = 1'b0;
      step(10);
      chk(18'(oq_n), 18'h0);
      $display("test standard mode done");
      reset_all(1'b1, 1'b1);
      chk(18'(ft), 18'h1);
      chkf(expf(0, 1'b1));
      // {full, empty} offsets shifted in msb first
      ld_n = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         @(negedge wclk);
         #1;
         si = (8'h23 >> i) & 8'h1;
         sen_n = 1'b0;
      end
      @(negedge wclk);
      #1;
      sen_n = 1'b1;
      repeat (4)
      begin
         @(negedge wclk);
         #1;
         si = $random(seed);
      end
      si = 1'b0;
      ld_n = 1'b1;
      ofs_check();
      fill_drain(1'b1);
      for (int k = 0; k < 3; k++)
         dcfrf_far_model_i.push(18'($random(seed)));
      step(60);
      prst_n = 1'b0;
      step(6);
      prst_n = 1'b1;
      step(60);
      chk(18'(ft), 18'h1);
      chkf(expf(0, 1'b1));
      chk(q, 18'h0);
      ofs_check();
      $display("test fall-through and partial reset done");
      tally_and_finish();
   end
endmodule
